// file: ee_target.sv
// two-wire serial memory target: 4096 bytes, 32-byte pages
// assumes open-drain data pin resolved outside; clock pin sampled by clk
// Behaviour
// R1: data change with clock high is start/stop
// R2: falling data, clock high starts transaction
// R3: rising data, clock high ends transaction
// R4: stop after read enters standby
// R5: 8-bit words, ack low on ninth clock
// R6: standby at reset and after stop
// R7: controller recovers with clocks then start
// R8: top four address bits hold type code
// R9: next three bits match select inputs
// R10: unconnected select inputs count as low
// R11: module variant needs three zero bits
// R12: address lsb high reads, low writes
// R13: ack on match, else back to standby
// R14: write protect blocks all array writes
// R15: byte write: device, two addresses, data
// R16: internal write ends within five ms
// R17: bus ignored during internal write
// R18: page write up to 32 bytes
// R19: only low five address bits wrap
// R20: no device ack while write runs
// R21: reject short spikes on both inputs
// R22: sample on rise, drive after fall
// R23: twelve-bit word address, 128 pages
// R24: address counter holds last plus one
// R25: reads continue while controller acknowledges
// R26: words travel msb first
// R27: upper four bits of first byte ignored
`include "ee_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ee_target #(
  parameter int GLITCH_CYCLES = `EE_GLITCH_CYCLES,
  parameter int WRITE_CYCLES  = `EE_WRITE_CYCLES,
  parameter int WCNT_W        = `EE_WCNT_W
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bus pins
  input  wire logic scl_pin,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  // straps and protection
  input  wire logic addr_select_bit2,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit0,
  input  wire logic module_variant,
  input  wire logic write_protect,
  // status
  output var  logic standby,
  output var  logic write_busy
);

  localparam logic [7:0]        GLAST = 8'(GLITCH_CYCLES);
  localparam logic [WCNT_W-1:0] WLAST = WCNT_W'(WRITE_CYCLES - 1);
  localparam logic [WCNT_W-1:0] WPAGE = WCNT_W'(`EE_PAGE_BYTES);

  // ==========================================================
  // input synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [4:0] pin_sync1;
  logic [4:0] pin_sync2;

  // two flops on every outside input, first flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      pin_sync1 <= 5'h00;
      pin_sync2 <= 5'h00;
    end else begin
      scl_sync  <= {scl_sync[0], scl_pin};
      sda_sync  <= {sda_sync[0], sda_in};
      pin_sync1 <= {write_protect, module_variant, addr_select_bit2, addr_select_bit1, addr_select_bit0};
      pin_sync2 <= pin_sync1;
    end
  end

  wire       wp_s  = pin_sync2[4];
  wire       mod_s = pin_sync2[3];
  // floating selects are pulled low on the board side
  wire [2:0] sel_s = mod_s ? 3'h0 : pin_sync2[2:0]; // R10 R11

  // ==========================================================
  // spike filter
  // a level is taken only after it has held one cycle past the limit
  function automatic logic [7:0] filt_next(input logic [7:0] cnt, input logic differ);
    filt_next = (differ && cnt != GLAST) ? cnt + 8'h01 : 8'h00;
  endfunction : filt_next

  logic       scl_f;
  logic       sda_f;
  logic [7:0] scl_cnt;
  logic [7:0] sda_cnt;
  wire        scl_diff = scl_sync[1] != scl_f;
  wire        sda_diff = sda_sync[1] != sda_f;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_f   <= 1'b1;
      sda_f   <= 1'b1;
      scl_cnt <= 8'h00;
      sda_cnt <= 8'h00;
    end else begin
      scl_cnt <= filt_next(scl_cnt, scl_diff); // R21
      sda_cnt <= filt_next(sda_cnt, sda_diff); // R21
      if (scl_diff && scl_cnt == GLAST) scl_f <= ~scl_f;
      if (sda_diff && sda_cnt == GLAST) sda_f <= ~sda_f;
    end
  end

  // ==========================================================
  // bus condition detection
  logic               scl_prev;
  logic               sda_prev;
  ee_pkg::ee_bus_ev_t ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  // data moving under a high clock is never a data bit
  assign ev.scl_rise = scl_f & ~scl_prev;
  assign ev.scl_fall = ~scl_f & scl_prev;
  assign ev.start    = scl_f & scl_prev & sda_prev & ~sda_f; // R1 R2
  assign ev.stop     = scl_f & scl_prev & ~sda_prev & sda_f; // R1 R3

  // ==========================================================
  // transaction state
  ee_pkg::ee_state_t     state;
  logic [3:0]            bit_cnt;
  logic                  in_ack;
  logic                  m_nack;
  logic                  rd_dir;
  logic [7:0]            rx;
  logic [7:0]            tx;
  logic [`EE_ADDR_W-1:0] addr;
  logic [WCNT_W-1:0]     wcnt;
  logic [7:0]            mem [`EE_ARRAY_BYTES];
  logic [7:0]            page_buf [`EE_PAGE_BYTES];
  logic [31:0]           page_mask;

  wire byte_done = ev.scl_fall && !in_ack && bit_cnt == `EE_BYTE_LAST;
  wire ack_end   = ev.scl_fall && in_ack;
  wire dev_match = rx[`EE_TYPE_HI:`EE_TYPE_LO] == `EE_DEVICE_TYPE
                && rx[`EE_SEL_HI:`EE_SEL_LO] == sel_s; // R8 R9
  wire bus_live  = state != ee_pkg::st_busy;
  // next read byte starts after a device ack with read set, or a controller ack
  wire load_rd   = ack_end && ((state == ee_pkg::st_dev && rd_dir)
                || (state == ee_pkg::st_rdata && !m_nack));
  wire [7:0] rd_byte = mem[addr];
  wire buf_we    = byte_done && state == ee_pkg::st_wdata && !wp_s; // R14
  wire commit    = ev.stop && bus_live && page_mask != 32'h0 && !wp_s; // R14 R15
  wire mem_we    = state == ee_pkg::st_busy && wcnt < WPAGE && page_mask[wcnt[4:0]];
  wire busy_done = state == ee_pkg::st_busy && wcnt == WLAST;
  wire [4:0] offs_inc = addr[`EE_OFFS_POS] + 5'h01;

  // protocol sequencer; all pin events ignored while writing
  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= ee_pkg::st_idle; // R6
      bit_cnt <= 4'h0;
      in_ack  <= 1'b0;
      m_nack  <= 1'b1;
      rd_dir  <= 1'b0;
      rx      <= 8'h00;
      tx      <= 8'h00;
      addr    <= 12'h000;
      wcnt    <= '0;
      sda_oe  <= 1'b0;
    end else if (ev.start && bus_live) begin // R2 R17 R20
      state   <= ee_pkg::st_dev;
      bit_cnt <= 4'h0;
      in_ack  <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ev.stop && bus_live) begin // R3 R4
      state   <= commit ? ee_pkg::st_busy : ee_pkg::st_idle;
      in_ack  <= 1'b0;
      sda_oe  <= 1'b0;
      wcnt    <= '0;
    end else if (state == ee_pkg::st_busy) begin // R16 R17
      wcnt    <= wcnt + 1'b1;
      if (busy_done) state <= ee_pkg::st_idle;
    end else if (state == ee_pkg::st_rdata) begin
      if (ev.scl_rise) begin // R22
        if (in_ack) m_nack <= sda_f;
        else bit_cnt <= bit_cnt + 4'h1;
      end else if (load_rd) begin // R25
        in_ack  <= 1'b0;
        bit_cnt <= 4'h0;
        sda_oe  <= ~rd_byte[7]; // R26
        tx      <= {rd_byte[6:0], 1'b0};
        addr    <= addr + 12'h001;
      end else if (ack_end) begin
        // declined: stay silent in the read so that the closing stop lands here
        tx      <= 8'hff; // R4 R25
        in_ack  <= 1'b0;
      end else if (byte_done) begin
        sda_oe  <= 1'b0;
        in_ack  <= 1'b1;
      end else if (ev.scl_fall) begin // R22
        sda_oe  <= ~tx[7]; // R26
        tx      <= {tx[6:0], 1'b0};
      end
    end else if (state != ee_pkg::st_idle) begin
      if (ev.scl_rise && !in_ack) begin // R22 R26
        rx      <= {rx[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_done) begin // R5
        in_ack  <= 1'b1;
        sda_oe  <= 1'b1;
        case (state)
          ee_pkg::st_dev: begin
            rd_dir <= rx[0]; // R12
            if (!dev_match) begin // R13
              state  <= ee_pkg::st_idle;
              in_ack <= 1'b0;
              sda_oe <= 1'b0;
            end
          end
          ee_pkg::st_ahi: addr[`EE_HI_ADDR_POS] <= rx[`EE_HI_ADDR_BITS]; // R23 R27
          ee_pkg::st_alo: addr[`EE_LO_ADDR_POS] <= rx; // R23
          ee_pkg::st_wdata: addr <= {addr[`EE_PAGE_POS], offs_inc}; // R19 R24
          default: ;
        endcase
      end else if (load_rd) begin // R12
        state   <= ee_pkg::st_rdata;
        in_ack  <= 1'b0;
        bit_cnt <= 4'h0;
        m_nack  <= 1'b1;
        sda_oe  <= ~rd_byte[7];
        tx      <= {rd_byte[6:0], 1'b0};
        addr    <= addr + 12'h001; // R24
      end else if (ack_end) begin // R15 R18
        in_ack  <= 1'b0;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
        case (state)
          ee_pkg::st_dev: state <= ee_pkg::st_ahi;
          ee_pkg::st_ahi: state <= ee_pkg::st_alo;
          default:        state <= ee_pkg::st_wdata;
        endcase
      end
    end
  end

  // ==========================================================
  // page buffer: bytes wait here until the stop commits them
  always_ff @(posedge clk) begin
    if (rst) begin
      page_mask <= 32'h0;
    end else if ((ev.start && bus_live) || busy_done) begin
      page_mask <= 32'h0; // an unstopped write is dropped
    end else if (buf_we) begin
      page_mask[addr[`EE_OFFS_POS]] <= 1'b1; // R18 R19
    end
  end

  always_ff @(posedge clk) begin
    if (buf_we) page_buf[addr[`EE_OFFS_POS]] <= rx;
  end

  // array update, one byte per cycle at the start of the write cycle
  always_ff @(posedge clk) begin
    if (mem_we) mem[{addr[`EE_PAGE_POS], wcnt[4:0]}] <= page_buf[wcnt[4:0]];
  end

  // ==========================================================
  // registered status and the never-high data level
  always_ff @(posedge clk) begin
    if (rst) begin
      standby    <= 1'b1; // R6
      write_busy <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      standby    <= state == ee_pkg::st_idle; // R4 R6
      write_busy <= state == ee_pkg::st_busy;
      sda_out    <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_stop_s;
    ev.stop && state == ee_pkg::st_rdata;
  endsequence

  sequence dev_hit_s;
    byte_done && state == ee_pkg::st_dev && dev_match;
  endsequence

  start_opens_a: assert property (ev.start && bus_live |=> state == ee_pkg::st_dev && !sda_oe) // R2
    else $error("start did not open a transaction");
  read_standby_a: assert property (read_stop_s |=> state == ee_pkg::st_idle ##1 standby) // R4
    else $error("stop after read did not reach standby");
  dev_ack_a: assert property (dev_hit_s |=> sda_oe && in_ack) // R5 R13
    else $error("matching address not acknowledged");
  dev_miss_a: assert property (byte_done && state == ee_pkg::st_dev && !dev_match
                               |=> !sda_oe && state == ee_pkg::st_idle) // R13
    else $error("mismatching address acknowledged");
  busy_quiet_a: assert property (state == ee_pkg::st_busy |-> !sda_oe ##1 !sda_oe) // R17 R20
    else $error("data driven during internal write");
  protect_a: assert property (ev.stop && bus_live && wp_s |=> state != ee_pkg::st_busy) // R14
    else $error("write cycle started while protected");
  page_hold_a: assert property (buf_we |=> $stable(addr[`EE_PAGE_POS])) // R19
    else $error("page bits moved during page write");
  busy_end_a: assert property (busy_done |=> state == ee_pkg::st_idle ##1 !write_busy) // R16
    else $error("write cycle overran");
  drive_fall_a: assert property (state == ee_pkg::st_rdata && $changed(sda_oe)
                                 |-> $past(ev.scl_fall) || $past(ev.stop) || $past(ev.start)) // R22
    else $error("read data changed away from clock fall");

  // a filtered level moves only once the whole spike window has passed
  clock_reject_a: assert property ($changed(scl_f) |-> $past(scl_cnt) == GLAST) // R21
    else $error("clock level taken inside the spike window");
  spike_reject_a: assert property ($changed(sda_f) |-> $past(sda_cnt) == GLAST) // R21
    else $error("data level taken inside the spike window");
  // the module variant answers only to an all-zero select field
  variant_sel_a: assert property (byte_done && state == ee_pkg::st_dev && mod_s // R11
                                  && rx[`EE_SEL_HI:`EE_SEL_LO] != 3'h0 |=> !sda_oe)
    else $error("module variant matched a nonzero select");
  // every received data byte is acknowledged, protected or not
  data_ack_a: assert property (byte_done && state == ee_pkg::st_wdata |=> sda_oe && in_ack) // R5 R18
    else $error("data byte not acknowledged");
  // each byte sent advances the counter by one, wrapping at the array end
  rd_advance_a: assert property (load_rd |=> addr == $past(addr) + 12'h001) // R24
    else $error("address counter did not advance on read");

endmodule : ee_target

`default_nettype wire

// file: ee_consts.svh
// named constants for the two-wire memory target
// assumes a 250 MHz core clock; included by bare name
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

// core clock
`define EE_CLK_PERIOD_PS   4000
// input spike rejection, worst supply
`define EE_GLITCH_NS       100
`define EE_GLITCH_CYCLES   ((`EE_GLITCH_NS * 1000 + `EE_CLK_PERIOD_PS - 1) / `EE_CLK_PERIOD_PS)
// internal_write_time, longest allowed
`define EE_WRITE_TIME_MS   5
// worked in ns per cycle so the product stays inside a 32-bit int
`define EE_WRITE_CYCLES    ((`EE_WRITE_TIME_MS * 1000000) / (`EE_CLK_PERIOD_PS / 1000))
`define EE_WCNT_W          21
// word and array geometry
`define EE_BIT_CNT_W       4
`define EE_BYTE_LAST       4'h8
`define EE_ADDR_W          12
`define EE_PAGE_BYTES      32
`define EE_ARRAY_BYTES     4096
// address byte fields
`define EE_TYPE_HI         7
`define EE_TYPE_LO         4
`define EE_SEL_HI          3
`define EE_SEL_LO          1
`define EE_HI_ADDR_BITS    3:0
`define EE_HI_ADDR_POS     11:8
`define EE_LO_ADDR_POS     7:0
`define EE_PAGE_POS        11:5
`define EE_OFFS_POS        4:0
// neutral device-type code; value is arbitrary
`define EE_DEVICE_TYPE     4'h5

`endif

// file: ee_pkg.sv
// types shared by the two-wire memory target
// assumes ee_consts.svh supplies all numeric constants
`default_nettype none

package ee_pkg;

  // transaction state of the target
  typedef enum logic [2:0] {
    st_idle,
    st_dev,
    st_ahi,
    st_alo,
    st_wdata,
    st_rdata,
    st_busy
  } ee_state_t;

  // bus conditions seen after filtering, one-cycle pulses
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } ee_bus_ev_t;

endpackage : ee_pkg

`default_nettype wire

// file: ee_ctrl_model.sv
// two-wire controller model: frames, words, recovery, spikes
// assumes a pull-up on data; the bench resolves the wire
`timescale 1ns/1ps
`default_nettype none
// ====================
// controller
module ee_ctrl_model (
  // bus
  output var  logic scl,
  output var  logic pull,
  input  wire logic sda
);
  // idle bus: clock stands high between frames
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  // one 48 ns clock; long low phase leaves room for the target's filter lag
  task automatic bit_c(input logic b, output logic r);
    #12 pull = !b;
    #20 scl = 1'b1;
    #12 r = sda;
    #4 scl = 1'b0;
  endtask : bit_c
  // falling data with clock high
  task automatic start_c();
    #24 pull = 1'b0;
    #12 scl = 1'b1;
    #12 pull = 1'b1;
    #12 scl = 1'b0;
  endtask : start_c
  // rising data with clock high, then idle
  task automatic stop_c();
    #12 pull = 1'b1;
    #12 scl = 1'b1;
    #12 pull = 1'b0;
    #48;
  endtask : stop_c
  // word out, then the ninth-clock answer
  task automatic wr(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(b[i], r);
    bit_c(1'b1, r);
    a = (r === 1'b0);
  endtask : wr
  // word in, then ack to go on or nack to end
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, r);
      d[i] = r;
    end
    bit_c(!more, r);
  endtask : rd
  // clocks until data reads high, then a fresh start
  task automatic recover();
    logic r;
    r = 1'b0;
    for (int i = 0; i < 9 && !r; i++) bit_c(1'b1, r);
    start_c();
  endtask : recover
  // data spike far shorter than the filter window
  task automatic spike();
    pull = 1'b1;
    #4 pull = 1'b0;
  endtask : spike
endmodule : ee_ctrl_model
`default_nettype wire

// file: ee_target_bench.sv
// self-checking bench for the two-wire memory target
// assumes the controller model; data wire has a pull-up
`include "ee_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
// ====================
// bench top
module ee_target_bench;
  logic       clk, rst, scl, pull, sda_out, sda_oe, standby, write_busy;
  logic       variant, wp, ack;
  logic [2:0] strap, sel;
  logic [7:0] d;
  int         errors, checked;
  logic [7:0] pg [4] = '{8'h3c, 8'ha5, 8'h0f, 8'hc3};
  // open-drain wire: low if either party pulls
  wire        sda = !(sda_oe && !sda_out) && !pull;

  // short write time keeps the run brief
  ee_target #(.GLITCH_CYCLES(2), .WRITE_CYCLES(400)) u_dut (
    .clk(clk), .rst(rst), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_bit2(strap[2]), .addr_select_bit1(strap[1]), .addr_select_bit0(strap[0]),
    .module_variant(variant), .write_protect(wp), .standby(standby), .write_busy(write_busy));
  ee_ctrl_model u_ctl (.scl(scl), .pull(pull), .sda(sda));

  // 250 MHz core clock
  initial clk = 1'b0;
  always #2 clk = !clk;

  task automatic dev(input logic rw);
    u_ctl.start_c();
    u_ctl.wr({`EE_DEVICE_TYPE, sel, rw}, ack);
  endtask : dev
  // dummy write that loads the word address, left open
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    dev(1'b0);
    `CHECK(ack, 1'b1)
    u_ctl.wr(hi, ack);
    `CHECK(ack, 1'b1)
    u_ctl.wr(lo, ack);
    `CHECK(ack, 1'b1)
  endtask : set_addr
  // random read of two bytes, sequential by ack
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e0, input logic [7:0] e1);
    set_addr({4'h0, a[11:8]}, a[7:0]);
    dev(1'b1);
    `CHECK(ack, 1'b1)
    u_ctl.rd(1'b1, d);
    `CHECK(d, e0)
    u_ctl.rd(1'b0, d);
    `CHECK(d, e1)
    u_ctl.stop_c();
    `CHECK(standby, 1'b1)
  endtask : rd_chk

  task automatic t_reset();
    `CHECK(standby, 1'b1)
    `CHECK(write_busy, 1'b0)
    `CHECK(sda_oe, 1'b0)
    `CHECK(sda_out, 1'b0)
  endtask : t_reset
  // a false start would drop standby for a cycle, so look at every cycle
  task automatic t_spike();
    u_ctl.spike();
    repeat (20) begin
      @(negedge clk);
      `CHECK(standby, 1'b1)
    end
  endtask : t_spike
  // {ack, variant, straps, sent select, bad type}
  task automatic t_addr();
    logic [8:0] tc [5] = '{9'h15a, 9'h058, 9'h05b, 9'h1d0, 9'h0da};
    foreach (tc[i]) begin
      @(negedge clk);
      {variant, strap} = tc[i][7:4];
      sel = tc[i][3:1];
      u_ctl.start_c();
      u_ctl.wr({(tc[i][0] ? ~`EE_DEVICE_TYPE : `EE_DEVICE_TYPE), sel, 1'b0}, ack);
      `CHECK(ack, tc[i][8])
      if (!ack) begin
        repeat (10) @(negedge clk);
        `CHECK(standby, 1'b1)
      end
      u_ctl.stop_c();
    end
    @(negedge clk);
    {variant, strap} = 4'h3;
    sel = 3'h3;
  endtask : t_addr
  // page write across the page end; upper nibble of hi byte is junk
  task automatic t_page();
    set_addr(8'hf3, 8'h1e);
    foreach (pg[i]) begin
      u_ctl.wr(pg[i], ack);
      `CHECK(ack, 1'b1)
    end
    u_ctl.stop_c();
    `CHECK(write_busy, 1'b1)
    dev(1'b0);
    `CHECK(ack, 1'b0)
    u_ctl.stop_c();
    for (int n = 0; n < 500 && write_busy !== 1'b0; n++) @(negedge clk);
    `CHECK(write_busy, 1'b0)
    `CHECK(standby, 1'b1)
    rd_chk(12'h31e, pg[0], pg[1]);
    rd_chk(12'h300, pg[2], pg[3]);
  endtask : t_page
  task automatic t_protect();
    @(negedge clk);
    wp = 1'b1;
    set_addr(8'h03, 8'h00);
    u_ctl.wr(8'h5a, ack);
    `CHECK(ack, 1'b1)
    u_ctl.stop_c();
    `CHECK(write_busy, 1'b0)
    @(negedge clk);
    wp = 1'b0;
    rd_chk(12'h300, pg[2], pg[3]);
  endtask : t_protect
  // read cut off after three bits, then the recovery sequence
  task automatic t_recover();
    logic r;
    set_addr(8'h03, 8'h1e);
    dev(1'b1);
    repeat (3) u_ctl.bit_c(1'b1, r);
    u_ctl.recover();
    u_ctl.stop_c();
    rd_chk(12'h31e, pg[0], pg[1]);
  endtask : t_recover

  task automatic conclude();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    rst = 1'b1;
    {variant, wp, strap, sel} = 8'h00;
    errors = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_spike();
    t_addr();
    t_page();
    t_protect();
    t_recover();
    conclude();
  end
  // watchdog: several times the expected run of some 24 us
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule : ee_target_bench
`default_nettype wire
